// file: design/channel_assess_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz device clock and byte-wide register access
`ifndef CHANNEL_ASSESS_MAP_SVH
`define CHANNEL_ASSESS_MAP_SVH

`define ADDR_XCVR_STATUS     8'h01
`define ADDR_STATE_CMD       8'h02
`define ADDR_ASSESS_CTRL     8'h08
`define ADDR_ENERGY_THR      8'h09
`define ADDR_EXT_CTRL_ONE    8'h17

`define REQ_BIT              7
`define MODE_HI              6
`define MODE_LO              5
`define CHAN_HI              4
`define THR_HI               3
`define LBT_SEL_BIT          6
`define CMD_HI               4

`define ASSESS_CTRL_RST      7'h20
`define ENERGY_THR_RST       8'h77
`define EXT_CTRL_ONE_RST     8'h00
`define STATE_CMD_RST        5'h00

`define CMD_FORCE_RADIO_OFF  5'h03
`define CMD_FORCE_PLL_ON     5'h04

`define CLK_PERIOD_NS        20
`define ASSESS_SYMBOLS       4'h8
`define PROC_DELAY_NS        12000
`define PROC_DELAY_CYCLES    ((`PROC_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ED_STEP_CDB          12'h0cf
`define LBT_SLOT_US          500
`define LBT_FIXED_US         5000
`define LBT_RAND_MAX_US      10000
`define LBT_SLOT_CYCLES      ((`LBT_SLOT_US * 1000) / `CLK_PERIOD_NS)
`define LBT_FIXED_SLOTS      5'(`LBT_FIXED_US / `LBT_SLOT_US)
`define LBT_RAND_SPAN        4'((`LBT_RAND_MAX_US - `LBT_FIXED_US) / `LBT_SLOT_US)
`define LFSR_SEED            8'h5a

`endif

// file: design/channel_assess_pkg.sv
// types shared by the channel assessment block
// assumes the constants of channel_assess_map.svh
package channel_assess_pkg;
  typedef enum logic [1:0] {MODE_CS_OR_ED, MODE_ED, MODE_CS, MODE_CS_AND_ED} assess_mode_t;
  typedef enum logic [1:0] {C_IDLE, C_MEAS, C_PROC} cca_state_t;
  typedef enum logic       {L_IDLE, L_LISTEN} lbt_state_t;
endpackage

// file: design/countdown.sv
// loadable down counter that stops at zero
// assumes the owner loads it before relying on zero
`timescale 1ns/100ps
module countdown #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         en,
  output logic      [W-1:0] count,
  output logic              zero
);
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (en && (count != '0)) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero = (count == '0);
endmodule

// file: design/channel_assess.sv
// channel assessment and listen-before-talk control with its registers
// assumes a synchronous register port from the serial engine and
// measurement inputs from the receiver, all on CLK
//
// Functional notes
// - finished measurement updates idle flag; request clears
// - idle flag: 0 busy, 1 idle, reset 0
// - request bit 7 self-clears once taken
// - mode field 6:5 selects method, reset 1
// - energy busy above base plus 2.07 dB steps
// - mode 0 ORs, mode 3 ANDs both decisions
// - listen fixed 5 ms, then send at once
// - busy: relisten random 5..10 ms, repeat
// - acknowledgement frames skip listening
// - listen only in extended mode, select bit
// - backoff retries and exponents ignored while listening
// - force commands abort ongoing listening
// - listening uses same mode and threshold
// - request clears complete flag; end sets it
// - end after 8 symbols plus 12 us
// - request outside receive: done, no measurement
`timescale 1ns/100ps
`include "channel_assess_map.svh"
module channel_assess #(
  parameter int SLOT_CYCLES = `LBT_SLOT_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [4:0]  TRX_STATE,
  input  wire logic        RX_STATE_BASIC,
  input  wire logic        SYMBOL_TICK,
  input  wire logic [11:0] POWER_ABOVE_BASE,
  input  wire logic        CARRIER_DETECT,
  input  wire logic        EXT_MODE,
  input  wire logic        LBT_START,
  input  wire logic        ACK_FRAME,
  output logic             DONE_EVENT,
  output logic             LBT_LISTENING,
  output logic             LBT_CLEAR,
  output logic             LBT_ABORT
);
  import channel_assess_pkg::*;

  // register file
  logic [6:0]   assess_control;
  logic [7:0]   energy_threshold_setting;
  logic [7:0]   extended_control_one;
  logic [4:0]   state_command_field;
  logic [6:0]   next_assess_control;
  logic [7:0]   next_energy_threshold_setting;
  logic [7:0]   next_extended_control_one;
  logic [4:0]   next_state_command_field;
  logic [7:0]   next_rdata;
  logic         assess_complete_flag;
  logic         channel_idle_flag;

  logic         assess_request_bit;
  logic         cancel;
  assess_mode_t assess_method_sel;
  logic [3:0]   energy_threshold_field;
  logic         listen_mode_select;
  logic [11:0]  thr_level;
  logic         energy_busy;
  logic         busy_now;

  assign assess_request_bit     = REG_WR && (REG_ADDR == `ADDR_ASSESS_CTRL) && REG_WDATA[`REQ_BIT];
  assign cancel                 = REG_WR && (REG_ADDR == `ADDR_STATE_CMD) &&
                                  ((REG_WDATA[`CMD_HI:0] == `CMD_FORCE_PLL_ON) ||
                                   (REG_WDATA[`CMD_HI:0] == `CMD_FORCE_RADIO_OFF));
  assign assess_method_sel      = assess_mode_t'(assess_control[`MODE_HI:`MODE_LO]);
  assign energy_threshold_field = energy_threshold_setting[`THR_HI:0];
  assign listen_mode_select     = extended_control_one[`LBT_SEL_BIT];

  // channel decision, shared by manual assessment and listening
  always_comb begin
    thr_level   = 12'(energy_threshold_field) * `ED_STEP_CDB;
    energy_busy = POWER_ABOVE_BASE > thr_level;
    unique case (assess_method_sel)
      MODE_CS_OR_ED:  busy_now = energy_busy || CARRIER_DETECT;
      MODE_ED:        busy_now = energy_busy;
      MODE_CS:        busy_now = CARRIER_DETECT;
      MODE_CS_AND_ED: busy_now = energy_busy && CARRIER_DETECT;
    endcase
  end

  always_comb begin
    next_assess_control           = assess_control;
    next_energy_threshold_setting = energy_threshold_setting;
    next_extended_control_one     = extended_control_one;
    next_state_command_field      = state_command_field;
    if (REG_WR) begin
      unique case (REG_ADDR)
        `ADDR_ASSESS_CTRL:  next_assess_control           = REG_WDATA[6:0];
        `ADDR_ENERGY_THR:   next_energy_threshold_setting = REG_WDATA;
        `ADDR_EXT_CTRL_ONE: next_extended_control_one     = REG_WDATA;
        `ADDR_STATE_CMD:    next_state_command_field      = REG_WDATA[`CMD_HI:0];
        default: ;
      endcase
    end
    unique case (REG_ADDR)
      `ADDR_XCVR_STATUS:  next_rdata = {assess_complete_flag, channel_idle_flag, 1'b0, TRX_STATE};
      `ADDR_STATE_CMD:    next_rdata = {3'h0, state_command_field};
      `ADDR_ASSESS_CTRL:  next_rdata = {1'b0, assess_control};
      `ADDR_ENERGY_THR:   next_rdata = energy_threshold_setting;
      `ADDR_EXT_CTRL_ONE: next_rdata = extended_control_one;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      assess_control           <= `ASSESS_CTRL_RST;
      energy_threshold_setting <= `ENERGY_THR_RST;
      extended_control_one     <= `EXT_CTRL_ONE_RST;
      state_command_field      <= `STATE_CMD_RST;
      REG_RDATA                <= 8'h00;
      REG_RVALID               <= 1'b0;
    end else begin
      assess_control           <= next_assess_control;
      energy_threshold_setting <= next_energy_threshold_setting;
      extended_control_one     <= next_extended_control_one;
      state_command_field      <= next_state_command_field;
      REG_RDATA                <= REG_RD ? next_rdata : REG_RDATA;
      REG_RVALID               <= REG_RD;
    end
  end

  // manual assessment
  cca_state_t cstate;
  cca_state_t next_cstate;
  logic       busy_acc;
  logic       next_busy_acc;
  logic       measured;
  logic       next_measured;
  logic       next_complete;
  logic       next_idle;
  logic       next_done_event;
  logic       sym_load;
  logic       proc_load;
  logic       sym_zero;
  logic       proc_zero;
  logic       meas_end;
  logic [3:0] sym_cnt;
  logic [9:0] proc_cnt;

  assign meas_end = (cstate == C_PROC) && proc_zero;

  always_comb begin
    next_cstate     = cstate;
    next_busy_acc   = busy_acc;
    next_measured   = measured;
    next_complete   = assess_complete_flag;
    next_idle       = channel_idle_flag;
    next_done_event = 1'b0;
    sym_load        = 1'b0;
    proc_load       = 1'b0;
    unique case (cstate)
      C_IDLE: ;
      C_MEAS: begin
        next_busy_acc = busy_acc || busy_now;
        if (sym_zero) begin
          next_cstate = C_PROC;
          proc_load   = 1'b1;
        end
      end
      C_PROC: begin
        if (proc_zero) begin
          next_cstate     = C_IDLE;
          next_complete   = 1'b1;
          next_idle       = measured && !busy_acc;
          next_done_event = 1'b1;
        end
      end
    endcase
    // a new request restarts; a completion in the same cycle still lands
    if (assess_request_bit) begin
      if (!meas_end) begin
        next_complete = 1'b0;
        next_idle     = 1'b0;
      end
      next_busy_acc = 1'b0;
      next_measured = RX_STATE_BASIC;
      if (RX_STATE_BASIC) begin
        next_cstate = C_MEAS;
        sym_load    = 1'b1;
      end else begin
        next_cstate = C_PROC;
        proc_load   = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cstate               <= C_IDLE;
      busy_acc             <= 1'b0;
      measured             <= 1'b0;
      assess_complete_flag <= 1'b0;
      channel_idle_flag    <= 1'b0;
      DONE_EVENT           <= 1'b0;
    end else begin
      cstate               <= next_cstate;
      busy_acc             <= next_busy_acc;
      measured             <= next_measured;
      assess_complete_flag <= next_complete;
      channel_idle_flag    <= next_idle;
      DONE_EVENT           <= next_done_event;
    end
  end

  countdown #(.W(4)) u_sym (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .load     (sym_load),
    .load_val (`ASSESS_SYMBOLS),
    .en       (SYMBOL_TICK),
    .count    (sym_cnt),
    .zero     (sym_zero)
  );

  countdown #(.W(10)) u_proc (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .load     (proc_load),
    .load_val (10'(`PROC_DELAY_CYCLES)),
    .en       (1'b1),
    .count    (proc_cnt),
    .zero     (proc_zero)
  );

  // listen before talk; backoff limits are not consulted here
  lbt_state_t lstate;
  lbt_state_t next_lstate;
  logic       busy_seen;
  logic       next_busy_seen;
  logic       next_clear;
  logic       next_abort;
  logic [7:0] lfsr;
  logic [7:0] next_lfsr;
  logic [3:0] rand_extra;
  logic       lbt_go;
  logic       slot_load;
  logic       pre_load;
  logic [4:0] slot_val;
  logic       slot_zero;
  logic       pre_zero;
  logic       slot_tick;
  logic [4:0] slot_cnt;
  logic [14:0] pre_cnt;

  assign lbt_go     = LBT_START && EXT_MODE && listen_mode_select && (lstate == L_IDLE);
  assign slot_tick  = (lstate == L_LISTEN) && pre_zero;
  assign rand_extra = (lfsr[3:0] > `LBT_RAND_SPAN) ? (lfsr[3:0] - 4'h5) : lfsr[3:0];

  always_comb begin
    next_lstate    = lstate;
    next_busy_seen = busy_seen;
    next_clear     = 1'b0;
    next_abort     = 1'b0;
    next_lfsr      = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    slot_load      = 1'b0;
    slot_val       = `LBT_FIXED_SLOTS;
    pre_load       = slot_tick;
    unique case (lstate)
      L_IDLE: begin
        if (lbt_go) begin
          if (ACK_FRAME) begin
            next_clear = 1'b1;
          end else begin
            next_lstate    = L_LISTEN;
            next_busy_seen = 1'b0;
            slot_load      = 1'b1;
            pre_load       = 1'b1;
          end
        end
      end
      L_LISTEN: begin
        next_busy_seen = busy_seen || busy_now;
        if (cancel) begin
          next_lstate = L_IDLE;
          next_abort  = 1'b1;
        end else if (slot_zero) begin
          if (!busy_seen) begin
            next_lstate = L_IDLE;
            next_clear  = 1'b1;
          end else begin
            next_busy_seen = 1'b0;
            slot_load      = 1'b1;
            pre_load       = 1'b1;
            slot_val       = `LBT_FIXED_SLOTS + 5'(rand_extra);
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lstate        <= L_IDLE;
      busy_seen     <= 1'b0;
      lfsr          <= `LFSR_SEED;
      LBT_CLEAR     <= 1'b0;
      LBT_ABORT     <= 1'b0;
      LBT_LISTENING <= 1'b0;
    end else begin
      lstate        <= next_lstate;
      busy_seen     <= next_busy_seen;
      lfsr          <= next_lfsr;
      LBT_CLEAR     <= next_clear;
      LBT_ABORT     <= next_abort;
      LBT_LISTENING <= (next_lstate == L_LISTEN);
    end
  end

  countdown #(.W(15)) u_pre (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .load     (pre_load),
    .load_val (15'(SLOT_CYCLES - 1)),
    .en       (1'b1),
    .count    (pre_cnt),
    .zero     (pre_zero)
  );

  countdown #(.W(5)) u_slot (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .load     (slot_load),
    .load_val (slot_val),
    .en       (slot_tick),
    .count    (slot_cnt),
    .zero     (slot_zero)
  );

  property p_req_clears;
    @(posedge CLK) disable iff (!ARST_N)
    (assess_request_bit && !meas_end) |=> (!assess_complete_flag && !channel_idle_flag);
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("request did not clear flags");

  property p_end_sets;
    @(posedge CLK) disable iff (!ARST_N)
    meas_end |=> (assess_complete_flag && DONE_EVENT && (channel_idle_flag == $past(measured && !busy_acc)));
  endproperty
  a_end_sets: assert property (p_end_sets) else $error("completion did not set result");

  property p_no_meas;
    @(posedge CLK) disable iff (!ARST_N)
    (assess_request_bit && !RX_STATE_BASIC) ##1 (!assess_request_bit)[*8] |-> (cstate == C_PROC) && !channel_idle_flag;
  endproperty
  a_no_meas: assert property (p_no_meas) else $error("measured outside receive state");

  property p_proc_delay;
    @(posedge CLK) disable iff (!ARST_N)
    (cstate == C_MEAS && sym_zero && !assess_request_bit) |-> ##[1:602] DONE_EVENT;
  endproperty
  a_proc_delay: assert property (p_proc_delay) else $error("processing delay overrun");

  property p_req_reads_zero;
    @(posedge CLK) disable iff (!ARST_N)
    (REG_RD && REG_ADDR == `ADDR_ASSESS_CTRL) |=> (REG_RVALID && !REG_RDATA[7]);
  endproperty
  a_req_reads_zero: assert property (p_req_reads_zero) else $error("request bit read as 1");

  property p_ack_skip;
    @(posedge CLK) disable iff (!ARST_N)
    (lbt_go && ACK_FRAME) |=> (LBT_CLEAR && !LBT_LISTENING);
  endproperty
  a_ack_skip: assert property (p_ack_skip) else $error("ack frame was not sent at once");

  property p_disabled;
    @(posedge CLK) disable iff (!ARST_N)
    (LBT_START && lstate == L_IDLE && !(EXT_MODE && listen_mode_select)) |=> (!LBT_CLEAR && !LBT_LISTENING);
  endproperty
  a_disabled: assert property (p_disabled) else $error("listening started while disabled");

  property p_cancel;
    @(posedge CLK) disable iff (!ARST_N)
    (cancel && lstate == L_LISTEN) |=> (LBT_ABORT && lstate == L_IDLE && !LBT_CLEAR);
  endproperty
  a_cancel: assert property (p_cancel) else $error("force command did not abort");

  property p_first_listen;
    @(posedge CLK) disable iff (!ARST_N)
    (lbt_go && !ACK_FRAME) |=> (slot_cnt == 5'h0a && LBT_LISTENING);
  endproperty
  a_first_listen: assert property (p_first_listen) else $error("fixed listen not 10 slots");

  property p_relisten;
    @(posedge CLK) disable iff (!ARST_N)
    (lstate == L_LISTEN && slot_zero && busy_seen && !cancel) |=> (slot_cnt >= 5'h0a && slot_cnt <= 5'h14);
  endproperty
  a_relisten: assert property (p_relisten) else $error("random listen out of range");
endmodule

// file: verif/rx_front_model.sv
// receiver stand-in: symbol ticks, received power and carrier sense
// assumes the bench sets the busy levels and the threshold in use
`timescale 1ns/100ps
`include "channel_assess_map.svh"
module rx_front_model #(
  parameter int TICK = 8
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  thr,
  input  wire logic        ed_busy,
  input  wire logic        cs_busy,
  output logic             tick,
  output logic [11:0]      power,
  output logic             carrier
);
  int cnt;

  // one symbol pulse every TICK cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 0;
      tick <= 1'b0;
    end else begin
      cnt  <= (cnt == TICK - 1) ? 0 : cnt + 1;
      tick <= (cnt == TICK - 1);
    end
  end

  // exactly on the threshold when quiet, one count above when busy
  assign power   = `ED_STEP_CDB * thr + {11'h000, ed_busy};
  assign carrier = cs_busy;
endmodule

// file: verif/testbench.sv
// self-checking bench for channel_assess with a receiver stand-in
// assumes the design files and channel_assess_map.svh on the include path
`timescale 1ns/100ps
`include "channel_assess_map.svh"
module testbench;
  localparam int SLOT = 4;
  localparam int TICK = 8;
  logic        clk, arst_n, wr, rd, rvalid, rx_basic, ext_mode, lbt_start;
  logic        ack_frame, ed_busy, cs_busy, tick, carrier, done_ev, lst;
  logic        listening, clear, abort_ev;
  logic [7:0]  addr, wdata, rdata;
  logic [4:0]  trx_state, code;
  logic [3:0]  thr;
  logic [11:0] power;
  int          bad_count, checked, cycles, n;

  channel_assess #(.SLOT_CYCLES(SLOT)) u_dut (
    .CLK              (clk),
    .ARST_N           (arst_n),
    .REG_ADDR         (addr),
    .REG_WR           (wr),
    .REG_RD           (rd),
    .REG_WDATA        (wdata),
    .REG_RDATA        (rdata),
    .REG_RVALID       (rvalid),
    .TRX_STATE        (trx_state),
    .RX_STATE_BASIC   (rx_basic),
    .SYMBOL_TICK      (tick),
    .POWER_ABOVE_BASE (power),
    .CARRIER_DETECT   (carrier),
    .EXT_MODE         (ext_mode),
    .LBT_START        (lbt_start),
    .ACK_FRAME        (ack_frame),
    .DONE_EVENT       (done_ev),
    .LBT_LISTENING    (listening),
    .LBT_CLEAR        (clear),
    .LBT_ABORT        (abort_ev)
  );

  rx_front_model #(.TICK(TICK)) u_rx (
    .clk     (clk),
    .arst_n  (arst_n),
    .thr     (thr),
    .ed_busy (ed_busy),
    .cs_busy (cs_busy),
    .tick    (tick),
    .power   (power),
    .carrier (carrier)
  );

  always #10 clk = ~clk;

  task automatic wrap_up;
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step();
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    step();
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    step();
    rd   = 1'b1;
    addr = a;
    step();
    rd = 1'b0;
    chk({what, " valid"}, 16'(rvalid), 16'h1);
    chk(what, 16'(rdata), 16'(exp));
  endtask

  task automatic wait_done;
    n = 0;
    while (done_ev !== 1'b1 && n < 2000) begin
      step();
      n++;
    end
  endtask

  // one manual assessment with a given mode and channel condition
  task automatic assess(input logic [1:0] m, input logic ed, input logic cs, input logic rx);
    logic idle;
    int   lo;
    int   hi;
    ed_busy  = ed;
    cs_busy  = cs;
    rx_basic = rx;
    case (m)
      2'h0: idle = !(ed || cs);
      2'h1: idle = !ed;
      2'h2: idle = !cs;
      default: idle = !(ed && cs);
    endcase
    if (!rx) idle = 1'b0;
    lo = rx ? 7 * TICK + 600 : 599;
    hi = rx ? 8 * TICK + 602 : 605;
    wr_reg(`ADDR_ASSESS_CTRL, {1'b1, m, 5'h00});
    rd_reg(`ADDR_XCVR_STATUS, {3'h0, trx_state}, "flags at request");
    wait_done();
    chk("done delay", 16'(n + 2 >= lo && n + 2 <= hi), 16'h1);
    rd_reg(`ADDR_XCVR_STATUS, {1'b1, idle, 1'b0, trx_state}, "result");
  endtask

  task automatic lbt_go(input logic ack);
    step();
    lbt_start = 1'b1;
    ack_frame = ack;
    step();
    lbt_start = 1'b0;
    ack_frame = 1'b0;
    lst       = listening;
  endtask

  task automatic lbt_wait(input int limit);
    n = 0;
    while (clear !== 1'b1 && abort_ev !== 1'b1 && n < limit) begin
      step();
      n++;
    end
  endtask

  initial begin
    clk       = 1'b0;
    arst_n    = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    trx_state = 5'h06;
    rx_basic  = 1'b1;
    ext_mode  = 1'b0;
    lbt_start = 1'b0;
    ack_frame = 1'b0;
    ed_busy   = 1'b0;
    cs_busy   = 1'b0;
    thr       = 4'h2;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    rd_reg(`ADDR_ASSESS_CTRL, 8'h20, "control reset");
    rd_reg(`ADDR_ENERGY_THR, 8'h77, "threshold reset");
    rd_reg(`ADDR_XCVR_STATUS, 8'h06, "status reset");
    rd_reg(`ADDR_EXT_CTRL_ONE, 8'h00, "ext reset");
    rd_reg(8'h33, 8'h00, "unmapped");
    wr_reg(`ADDR_XCVR_STATUS, 8'hff);
    rd_reg(`ADDR_XCVR_STATUS, 8'h06, "status read only");
    wr_reg(`ADDR_ENERGY_THR, 8'h72);
    rd_reg(`ADDR_ENERGY_THR, 8'h72, "threshold write");
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        assess(2'(m), k[0], k[1], 1'b1);
      end
    end
    assess(2'h1, 1'b0, 1'b0, 1'b0);
    wr_reg(`ADDR_ASSESS_CTRL, 8'h40);
    rd_reg(`ADDR_ASSESS_CTRL, 8'h40, "mode only");
    n = 0;
    repeat (700) begin
      step();
      if (done_ev === 1'b1) n++;
    end
    chk("no run on zero", 16'(n), 16'h0);
    rd_reg(`ADDR_XCVR_STATUS, 8'h86, "flags kept");
    // listening must stay off unless both enables are set
    for (int k = 0; k < 2; k++) begin
      ext_mode = k[0];
      wr_reg(`ADDR_EXT_CTRL_ONE, {1'b0, ~k[0], 6'h00});
      lbt_go(1'b0);
      lbt_wait(60);
      chk("no listen", 16'(lst), 16'h0);
      chk("no clear", 16'(n), 16'h3c);
    end
    wr_reg(`ADDR_EXT_CTRL_ONE, 8'h40);
    rd_reg(`ADDR_EXT_CTRL_ONE, 8'h40, "ext write");
    lbt_go(1'b1);
    lbt_wait(5);
    chk("ack no listen", 16'(lst), 16'h0);
    chk("ack clear", 16'(n <= 1), 16'h1);
    // energy busy but carrier-only mode: one fixed window
    ed_busy = 1'b1;
    lbt_go(1'b0);
    lbt_wait(400);
    chk("listen starts", 16'(lst), 16'h1);
    chk("fixed window", 16'(n >= 10 * SLOT - 1 && n <= 10 * SLOT + 3), 16'h1);
    step();
    chk("listen over", 16'(listening), 16'h0);
    ed_busy = 1'b0;
    cs_busy = 1'b1;
    lbt_go(1'b0);
    repeat (5) step();
    cs_busy = 1'b0;
    lbt_wait(400);
    chk("random window", 16'(n + 5 >= 20 * SLOT - 1 && n + 5 <= 30 * SLOT + 4), 16'h1);
    // each force command aborts listening and is stored
    for (int k = 0; k < 2; k++) begin
      code    = k[0] ? `CMD_FORCE_PLL_ON : `CMD_FORCE_RADIO_OFF;
      cs_busy = 1'b1;
      lbt_go(1'b0);
      lbt_wait(150);
      chk("still listening", 16'(listening), 16'h1);
      wr_reg(`ADDR_STATE_CMD, {3'h0, code});
      lbt_wait(3);
      chk("abort pulse", 16'(abort_ev), 16'h1);
      step();
      chk("listen aborted", 16'(listening), 16'h0);
      rd_reg(`ADDR_STATE_CMD, {3'h0, code}, "command stored");
    end
    wrap_up();
  end
endmodule
